// file: timer_gate_pkg.sv
/*
  Shared constants for the gated 16-bit timer: register map, control field
  positions, reset values, oscillator modes and prescale codes.
  Assumes a single 250 MHz bus clock domain; used by the prescaler and the top level.
*/
package timer_gate_pkg;

  localparam int CLK_PERIOD_NS = 4;

  // Byte addresses on the register bus
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // Control register fields
  localparam int BIT_TIMER_ON = 0;
  localparam int BIT_CLOCK_SOURCE = 1;
  localparam int BIT_EXT_SYNC = 2;
  localparam int BIT_LP_OSC_ENABLE = 3;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_GATE_ENABLE = 6;
  localparam int BIT_GATE_INVERT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Status register fields
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_LP_OSC_RUN = 1;

  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // System oscillator modes seen by the timer
  typedef enum logic [1:0] {
    OSC_INTERNAL_NO_CLKOUT,
    OSC_LOW_POWER,
    OSC_OTHER
  } osc_mode_t;

  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV2 = 2'h1;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h2;
  localparam logic [1:0] PRESCALE_DIV8 = 2'h3;

endpackage

// file: edge_sync.sv
/*
  Two-flop synchroniser with a rising-edge detector on the settled level.
  Assumes the input level is slow compared with aclk.
*/
`timescale 1ns/100ps
module edge_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Level in, synchronised level and rising edge out
  input wire logic async_in,
  output logic level,
  output logic rise
);
  logic meta;
  logic settled;
  logic prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      settled <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      settled <= meta;
      prev <= settled;
    end
  end

  assign level = settled;
  assign rise = settled & ~prev;
endmodule

// file: prescaler.sv
/*
  Input prescaler: passes one tick in 1, 2, 4 or 8 according to the select.
  Assumes clear is a one-cycle pulse from a count byte write.
*/
`timescale 1ns/100ps
module prescaler (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic [1:0] select,
  input wire logic clear,
  // Ticks
  input wire logic tick_in,
  output logic tick_out
);
  import timer_gate_pkg::*;

  logic [2:0] count;
  logic [2:0] mask;

  always_comb begin
    unique case (select)
      PRESCALE_DIV1: mask = 3'h0;
      PRESCALE_DIV2: mask = 3'h1;
      PRESCALE_DIV4: mask = 3'h3;
      PRESCALE_DIV8: mask = 3'h7;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count <= 3'h0;
    end else if (tick_in) begin
      count <= (count & mask) == mask ? 3'h0 : count + 3'h1;
    end
  end

  assign tick_out = tick_in && ((count & mask) == mask);
endmodule

// file: timer_gate_top.sv
/*
  Gated 16-bit timer/counter with AXI4-Lite register access: control byte,
  two count bytes, and a status word with the overflow flag.
  Assumes instr_tick pulses once per instruction cycle, and that external
  and LP oscillator clocks are slow levels sampled on aclk.
*/
// Functional notes
// - Gate enable ignored when timer off; when on, enables gating.
// - Prescale select 11/10/01/00 divides by 8/4/2/1.
// - With internal oscillator no clock out, LP enable bit turns LP oscillator on.
// - Sync control set leaves external clock unsynchronised; clear synchronises it.
// - Asynchronous mode counts through sleep; overflow can wake processor.
// - Count byte reads always return a valid value.
// - LP enable and clock source both set clock timer from LP oscillator, except in other oscillator modes.
// - LP system oscillator with timer option shares one oscillator circuit.
// - Sleep does not stop the LP oscillator; it clocks the timer in sleep only with sync control set (unsynchronised).
// - Other oscillator modes ignore the LP enable bit.
// - Internal oscillator mode with LP enable runs LP oscillator regardless of timer on.
// - Timer mode counts instruction cycles; counter mode counts external rising edges.
// - Overflow flag set when count rolls from FFFF to 0000.
// - Writing either count byte clears the prescale counter.
// - Gate invert bit inverts the gate signal for any source.
`timescale 1ns/100ps
module timer_gate_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock sources and gate
  input wire logic instr_tick,
  input wire logic external_count_clock_pin,
  input wire logic lp_osc_clock,
  input wire logic gate_in,
  // System state
  input wire timer_gate_pkg::osc_mode_t system_osc_mode,
  input wire logic sleep,
  // Outputs to the system
  output logic lp_osc_run,
  output logic overflow_flag,
  output logic wake_request
);
  import timer_gate_pkg::*;

  logic [7:0] timer_control;
  logic [15:0] count;
  logic aw_held;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic clear_prescale;
  logic next_overflow;
  logic timer_on;
  logic gate_enable;
  logic [1:0] input_prescale_select;
  logic lp_osc_timer_enable;
  logic external_sync_control;
  logic count_clock_source_select;
  logic gate_invert;
  logic lp_allowed;
  logic lp_osc_on;
  logic source_level;
  logic sync_rise;
  logic raw_prev;
  logic raw_rise;
  logic ext_tick;
  logic gate_open;
  logic count_tick;
  logic scaled_tick;
  logic wr_low;
  logic wr_high;

  assign timer_on = timer_control[BIT_TIMER_ON];
  assign count_clock_source_select = timer_control[BIT_CLOCK_SOURCE];
  assign external_sync_control = timer_control[BIT_EXT_SYNC];
  assign lp_osc_timer_enable = timer_control[BIT_LP_OSC_ENABLE];
  assign input_prescale_select = timer_control[BIT_PRESCALE_LO +: 2];
  assign gate_enable = timer_control[BIT_GATE_ENABLE];
  assign gate_invert = timer_control[BIT_GATE_INVERT];

  assign lp_allowed = (system_osc_mode == OSC_INTERNAL_NO_CLKOUT) || (system_osc_mode == OSC_LOW_POWER);
  assign lp_osc_on = lp_allowed && lp_osc_timer_enable;

  // oscillator runs through sleep; shared circuit in LP mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_osc_run <= 1'b0;
    end else begin
      lp_osc_run <= lp_osc_on || (system_osc_mode == OSC_LOW_POWER);
    end
  end

  // pick LP oscillator or external pin
  assign source_level = lp_osc_on ? lp_osc_clock : external_count_clock_pin;

  edge_sync u_edge_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(source_level),
    .level(),
    .rise(sync_rise)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_prev <= 1'b0;
    end else begin
      raw_prev <= source_level;
    end
  end
  assign raw_rise = source_level & ~raw_prev;

  // unsynchronised path keeps counting in sleep
  assign ext_tick = external_sync_control ? raw_rise : (sync_rise && !sleep);

  assign gate_open = !gate_enable || (gate_in ^ gate_invert);

  assign count_tick = timer_on && gate_open && (count_clock_source_select ? ext_tick : (instr_tick && !sleep));

  assign clear_prescale = wr_low || wr_high;

  prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .select(input_prescale_select),
    .clear(clear_prescale),
    .tick_in(count_tick),
    .tick_out(scaled_tick)
  );

  // Write channel holding; address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Readies are registered, so they look one cycle ahead at the holding state
  assign next_aw_held = (s_axi_awvalid && s_axi_awready) || (aw_held && !do_write);
  assign next_w_held = (s_axi_wvalid && s_axi_wready) || (w_held && !do_write);
  assign next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
    end
  end

  assign do_write = aw_held && w_held;
  assign wr_low = do_write && (aw_addr == ADDR_COUNT_LOW) && w_strb[0];
  assign wr_high = do_write && (aw_addr == ADDR_COUNT_HIGH) && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr == ADDR_CONTROL || aw_addr == ADDR_COUNT_LOW || aw_addr == ADDR_COUNT_HIGH ||
                      aw_addr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control <= CONTROL_RESET;
    end else if (do_write && aw_addr == ADDR_CONTROL && w_strb[0]) begin
      timer_control <= w_data[7:0];
    end
  end

  // counter with rollover; software write wins over a tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= COUNT_RESET;
    end else if (wr_low) begin
      count <= {count[15:8], w_data[7:0]};
    end else if (wr_high) begin
      count <= {w_data[7:0], count[7:0]};
    end else if (scaled_tick) begin
      count <= count + 16'h0001;
    end
  end

  // overflow flag, set wins over clear
  always_comb begin
    next_overflow = overflow_flag;
    if (do_write && aw_addr == ADDR_STATUS && w_strb[0] && w_data[BIT_OVERFLOW]) begin
      next_overflow = 1'b0;
    end
    if (scaled_tick && count == COUNT_MAX && !clear_prescale) begin
      next_overflow = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= next_overflow;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= sleep && next_overflow && !overflow_flag;
    end
  end

  // Read channel
  assign next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !next_rvalid;
    end
  end

  // reads sample the register copy, never a half-updated value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CONTROL: s_axi_rdata <= {24'h000000, timer_control};
        ADDR_COUNT_LOW: s_axi_rdata <= {24'h000000, count[7:0]};
        ADDR_COUNT_HIGH: s_axi_rdata <= {24'h000000, count[15:8]};
        ADDR_STATUS: s_axi_rdata <= {30'h0, lp_osc_run, overflow_flag};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions
  // rollover sets flag
  a_overflow_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (scaled_tick && count == COUNT_MAX && !clear_prescale) |=> overflow_flag && count == 16'h0000)
    else $error("rollover did not set overflow flag");
  a_count_hold_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (!timer_on && !wr_low && !wr_high) |=> count == $past(count))
    else $error("count moved while timer off");
  a_gate_blocks_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    (gate_enable && !(gate_in ^ gate_invert)) |-> !count_tick)
    else $error("tick passed a closed gate");
  a_write_clears_pre: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_low |=> u_prescaler.count == 3'h0)
    else $error("prescaler not cleared by count write");
  a_div8_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    (scaled_tick && input_prescale_select == PRESCALE_DIV8 && !clear_prescale) |=>
    !scaled_tick [*1] ##0 (u_prescaler.count == 3'h0))
    else $error("prescaler did not restart after tick");
  a_lp_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (system_osc_mode == OSC_OTHER) |=> !lp_osc_run)
    else $error("LP oscillator ran in other mode");
  a_lp_continuous: assert property (@(posedge aclk) disable iff (!aresetn)
    (system_osc_mode == OSC_INTERNAL_NO_CLKOUT && lp_osc_timer_enable) |=> lp_osc_run)
    else $error("LP oscillator not running");
  a_timer_mode_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    (timer_on && !count_clock_source_select && !gate_enable && instr_tick && !sleep) |-> count_tick)
    else $error("instruction tick missed");
  a_sleep_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep && !overflow_flag && scaled_tick && count == COUNT_MAX && !clear_prescale) |=> wake_request)
    else $error("no wake on overflow in sleep");
endmodule

// file: ext_clock_source.sv
/*
  Far-side model: external count clock or LP crystal oscillator giving bursts
  of rising edges. Assumes aclk is the bench clock; the clock stands low when idle.
*/
`timescale 1ns/100ps
module ext_clock_source #(
  parameter int HALF = 4
) (
  // Bench clock
  input wire logic aclk,
  // Burst request
  input wire logic load,
  input wire logic [7:0] edges,
  input wire logic use_lp,
  // Clock outputs
  output logic ext_clk,
  output logic lp_clk,
  output logic busy
);
  logic [7:0] left = 8'h00;
  int phase = 0;
  logic level = 1'b0;

  // Starts low so the first toggle of a burst is a rising edge
  always @(posedge aclk) begin
    if (load) begin
      left <= edges;
      phase <= 0;
      level <= 1'b0;
    end else if (left != 8'h00) begin
      if (phase == HALF - 1) begin
        phase <= 0;
        level <= !level;
        if (level)
          left <= left - 8'h01;
      end else begin
        phase <= phase + 1;
      end
    end
  end

  assign ext_clk = level && !use_lp;
  assign lp_clk = level && use_lp;
  assign busy = left != 8'h00;
endmodule

// file: timer1_clock_gate_control_test.sv
/*
  Self-checking bench for the gated timer: AXI4-Lite tasks and sequences.
  Assumes timer_gate_top and ext_clock_source; 250 MHz clock.
*/
`timescale 1ns/100ps
module timer1_clock_gate_control_test
  import timer_gate_pkg::*;
;
  logic aclk, aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, lp_osc_run, overflow_flag, wake_request;
  logic [1:0] bresp, rresp, r;
  logic instr_tick = 1'b0, gate_in = 1'b0, sleep = 1'b0, load = 1'b0, use_lp = 1'b0, busy, ext_clk, lp_clk;
  logic [7:0] edges = 8'h00;
  logic [31:0] d;
  logic [15:0] c, gc[2], first;
  logic wake_seen = 1'b0;
  osc_mode_t system_osc_mode = OSC_OTHER;
  int bad_count = 0, total_checks = 0, cycles = 0;

  timer_gate_top u_timer_gate_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .instr_tick(instr_tick), .external_count_clock_pin(ext_clk), .lp_osc_clock(lp_clk),
    .gate_in(gate_in), .system_osc_mode(system_osc_mode), .sleep(sleep), .lp_osc_run(lp_osc_run),
    .overflow_flag(overflow_flag), .wake_request(wake_request));
  ext_clock_source u_ext_clock_source (.aclk(aclk), .load(load), .edges(edges), .use_lp(use_lp),
    .ext_clk(ext_clk), .lp_clk(lp_clk), .busy(busy));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (wake_request === 1'b1)
      wake_seen <= 1'b1;
    if (cycles == 30000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [7:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      @(posedge aclk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic [1:0] resp;
    axi_write(a, v, resp);
    check("write response", {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] resp;
    axi_read(a, v, resp);
    check(what, exp, v);
  endtask

  task automatic set_count(input logic [15:0] v);
    wr(ADDR_COUNT_LOW, v[7:0]);
    wr(ADDR_COUNT_HIGH, v[15:8]);
  endtask

  // High, low, high again: a carry between the two byte reads is caught
  task automatic get_count(output logic [15:0] v);
    logic [31:0] hi, lo, hi2;
    logic [1:0] resp;
    axi_read(ADDR_COUNT_HIGH, hi, resp);
    axi_read(ADDR_COUNT_LOW, lo, resp);
    axi_read(ADDR_COUNT_HIGH, hi2, resp);
    if (hi2 !== hi)
      axi_read(ADDR_COUNT_LOW, lo, resp);
    v = {hi2[7:0], lo[7:0]};
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      instr_tick <= 1'b1;
      @(posedge aclk);
      instr_tick <= 1'b0;
    end
  endtask

  task automatic burst(input logic [7:0] n, input logic lp);
    @(posedge aclk);
    load <= 1'b1;
    edges <= n;
    use_lp <= lp;
    @(posedge aclk);
    load <= 1'b0;
    @(negedge aclk);
    while (busy) @(negedge aclk);
    repeat (8) @(posedge aclk);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("control reset", ADDR_CONTROL, {24'h0, CONTROL_RESET});
    rd_chk("status reset", ADDR_STATUS, 32'h0);
    get_count(c);
    check("count reset", {16'h0, COUNT_RESET}, {16'h0, c});
    axi_write(4'h2, 8'h01, r);
    check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_read(4'h6, d, r);
    check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    check("unmapped data", 32'h0, d);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CONTROL, 8'h00);
      set_count(16'h0000);
      wr(ADDR_CONTROL, {2'b00, p[1:0], 4'h1});
      ticks(16);
      wr(ADDR_CONTROL, 8'h00);
      get_count(c);
      check("prescaled count", 32'(16 >> p), {16'h0, c});
    end
    wr(ADDR_CONTROL, 8'h40);
    ticks(6);
    get_count(c);
    check("held count", 32'h2, {16'h0, c});
    wr(ADDR_CONTROL, 8'h31);
    ticks(5);
    wr(ADDR_CONTROL, 8'h30);
    set_count(16'h0000);
    wr(ADDR_CONTROL, 8'h31);
    ticks(11);
    wr(ADDR_CONTROL, 8'h00);
    get_count(c);
    check("prescaler cleared", 32'h1, {16'h0, c});
    for (int inv = 0; inv < 2; inv++) begin
      for (int g = 0; g < 2; g++) begin
        set_count(16'h0000);
        gate_in <= g[0];
        wr(ADDR_CONTROL, inv[0] ? 8'hC1 : 8'h41);
        ticks(8);
        wr(ADDR_CONTROL, 8'h00);
        get_count(gc[g]);
      end
      check("gated sum", 32'h8, {16'h0, gc[0] + gc[1]});
      check("gate blocks", {16'h0, inv[0] ? 16'h0008 : 16'h0000}, {16'h0, gc[0]});
      if (inv == 0)
        first = gc[0];
      else
        check("gate inverted", {16'h0, first}, {16'h0, gc[1]});
    end
    set_count(COUNT_MAX);
    wr(ADDR_CONTROL, 8'h01);
    ticks(1);
    wr(ADDR_CONTROL, 8'h00);
    get_count(c);
    check("rollover count", 32'h0, {16'h0, c});
    check("overflow port", 32'h1, {31'h0, overflow_flag});
    rd_chk("status flag", ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 8'h01);
    rd_chk("status cleared", ADDR_STATUS, 32'h0);
    set_count(16'h0000);
    wr(ADDR_CONTROL, 8'h03);
    burst(8'd5, 1'b0);
    wr(ADDR_CONTROL, 8'h00);
    get_count(c);
    check("external count", 32'h5, {16'h0, c});
    sleep <= 1'b1;
    wr(ADDR_CONTROL, 8'h03);
    burst(8'd4, 1'b0);
    wr(ADDR_CONTROL, 8'h00);
    sleep <= 1'b0;
    get_count(c);
    check("sync count in sleep", 32'h5, {16'h0, c});
    set_count(16'hFFFE);
    wr(ADDR_CONTROL, 8'h07);
    sleep <= 1'b1;
    burst(8'd2, 1'b0);
    sleep <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    get_count(c);
    check("async count in sleep", 32'h0, {16'h0, c});
    check("wake request", 32'h1, {31'h0, wake_seen});
    system_osc_mode <= OSC_INTERNAL_NO_CLKOUT;
    wr(ADDR_CONTROL, 8'h08);
    repeat (3) @(posedge aclk);
    check("lp run timer off", 32'h1, {31'h0, lp_osc_run});
    sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    check("lp run in sleep", 32'h1, {31'h0, lp_osc_run});
    sleep <= 1'b0;
    system_osc_mode <= OSC_OTHER;
    repeat (3) @(posedge aclk);
    check("lp enable ignored", 32'h0, {31'h0, lp_osc_run});
    system_osc_mode <= OSC_LOW_POWER;
    repeat (3) @(posedge aclk);
    check("lp shared circuit", 32'h1, {31'h0, lp_osc_run});
    system_osc_mode <= OSC_INTERNAL_NO_CLKOUT;
    wr(ADDR_CONTROL, 8'h00);
    repeat (3) @(posedge aclk);
    check("lp off", 32'h0, {31'h0, lp_osc_run});
    set_count(16'h0000);
    wr(ADDR_CONTROL, 8'h0B);
    burst(8'd3, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    get_count(c);
    check("lp clocked count", 32'h3, {16'h0, c});
    conclude();
  end
endmodule
